// file: cfl_pkg.sv
// package of constants and types for the cpu flag, low-power and break block
package cfl_pkg;

    // ****************************************
    // condition code register layout
    // ****************************************
    localparam int CFL_CC_C_BIT  = 0;
    localparam int CFL_CC_Z_BIT  = 1;
    localparam int CFL_CC_N_BIT  = 2;
    localparam int CFL_CC_I_BIT  = 3;
    localparam int CFL_CC_H_BIT  = 4;
    localparam int CFL_CC_V_BIT  = 7;
    localparam logic [7:0] CFL_CC_RESET = 8'h68;   // i set, bits 6:5 read one

    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [7:0] CFL_OP_BGEU = 8'h24;
    localparam logic [7:0] CFL_OP_BPLO = 8'h2e;
    localparam logic [7:0] CFL_OP_BPHI = 8'h2f;
    localparam logic [7:0] CFL_OP_TRAP = 8'h83;
    localparam logic [7:0] CFL_OP_IRET = 8'h80;
    localparam logic [7:0] CFL_OP_WAIT = 8'h8f;
    localparam logic [7:0] CFL_OP_STOP = 8'h8e;
    localparam logic [7:0] CFL_OP_ADD  = 8'hab;
    localparam logic [7:0] CFL_OP_SUB  = 8'ha0;
    localparam logic [7:0] CFL_OP_AND  = 8'ha4;
    localparam logic [7:0] CFL_OP_LSL  = 8'h48;
    localparam logic [7:0] CFL_OP_LSR  = 8'h44;
    localparam logic [7:0] CFL_OP_ROL  = 8'h49;
    localparam logic [7:0] CFL_OP_BRSET0 = 8'h00;

    // ****************************************
    // vectors and timing
    // ****************************************
    localparam logic [15:0] CFL_VEC_BREAK   = 16'hfffc;
    localparam logic [15:0] CFL_VEC_MONITOR = 16'hfefc;
    localparam int          CFL_BRANCH_CYCLES = 3;
    localparam int          CFL_BRANCH_LEN    = 2;
    localparam int          CFL_OSC_DELAY_NS  = 40960;
    localparam int          CFL_CLK_NS        = 10;
    localparam int          CFL_OSC_CYCLES    = CFL_OSC_DELAY_NS / CFL_CLK_NS;

    // ****************************************
    // register port addresses
    // ****************************************
    localparam logic [3:0] CFL_ADDR_CC   = 4'h0;
    localparam logic [3:0] CFL_ADDR_ACC  = 4'h1;
    localparam logic [3:0] CFL_ADDR_PCH  = 4'h2;
    localparam logic [3:0] CFL_ADDR_PCL  = 4'h3;
    localparam logic [3:0] CFL_ADDR_STAT = 4'h4;
    localparam logic [3:0] CFL_ADDR_CTRL = 4'h5;

    typedef enum logic [2:0] {
        CFL_FETCH, CFL_OPERAND, CFL_EXEC, CFL_LOWPWR, CFL_OSCWAIT, CFL_BREAK
    } cfl_state_t;

endpackage

// file: cfl_alu.sv
// alu producing result and carry for the supported operations
`timescale 1ns/1ps
module cfl_alu
    import cfl_pkg::*;
(
    input  wire logic [7:0] i_op,       // opcode
    input  wire logic [7:0] i_a,        // accumulator
    input  wire logic [7:0] i_m,        // operand
    input  wire logic       i_c,        // carry in
    output logic      [7:0] o_res,      // result byte
    output logic            o_c,        // carry out
    output logic            o_upd_c     // carry is updated
);

    // ****************************************
    // combinational alu
    // ****************************************
    always_comb begin
        logic [8:0] wide;
        wide    = 9'h000;
        o_res   = i_a;
        o_c     = i_c;
        o_upd_c = 1'b1;
        case (i_op)
            CFL_OP_ADD: begin
                wide  = {1'b0, i_a} + {1'b0, i_m};
                o_res = wide[7:0];
                o_c   = wide[8];
            end
            CFL_OP_SUB: begin
                wide  = {1'b0, i_a} - {1'b0, i_m};
                o_res = wide[7:0];
                o_c   = wide[8];
            end
            CFL_OP_LSL: begin
                o_res = {i_a[6:0], 1'b0};
                o_c   = i_a[7];
            end
            CFL_OP_LSR: begin
                o_res = {1'b0, i_a[7:1]};
                o_c   = i_a[0];
            end
            CFL_OP_ROL: begin
                o_res = {i_a[6:0], i_c};
                o_c   = i_a[7];
            end
            default: begin
                o_res   = i_a & i_m;
                o_upd_c = 1'b0;
            end
        endcase
    end

endmodule // cfl_alu

// file: cfl_branch.sv
// relative branch target and condition evaluation
`timescale 1ns/1ps
module cfl_branch
    import cfl_pkg::*;
(
    input  wire logic [7:0]  i_op,      // opcode
    input  wire logic [15:0] i_pc,      // pc at opcode
    input  wire logic [7:0]  i_rel,     // offset byte
    input  wire logic        i_c,       // carry flag
    input  wire logic        i_irq_pin, // external interrupt pin level
    output logic             o_is_br,   // opcode is a handled branch
    output logic             o_take,    // branch condition true
    output logic      [15:0] o_target   // pc + 2 + rel
);

    // ****************************************
    // condition decode
    // ****************************************
    always_comb begin
        o_is_br = 1'b1;
        o_take  = 1'b0;
        case (i_op)
            CFL_OP_BGEU: o_take = ~i_c;
            CFL_OP_BPHI: o_take = i_irq_pin;
            CFL_OP_BPLO: o_take = ~i_irq_pin;
            default:    o_is_br = 1'b0;
        endcase
    end

    // sign-extended offset added to the next-instruction address
    assign o_target = i_pc + 16'(CFL_BRANCH_LEN) + {{8{i_rel[7]}}, i_rel};

endmodule // cfl_branch

// file: cfl_core.sv
// cpu flag, low-power and break sequencing core
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

module cfl_core
    import cfl_pkg::*;
#(
    parameter int OSC_CYCLES = CFL_OSC_CYCLES  // oscillator settling count
)(
    input  wire logic        i_clk,       // 100 mhz bus clock
    input  wire logic        i_sys_rst,   // async reset, active high
    input  wire logic        i_ce,        // clock enable, freezes state when low
    input  wire logic [7:0]  i_opcode,    // fetched opcode
    input  wire logic [7:0]  i_operand,   // operand or offset byte
    input  wire logic        i_op_valid,  // opcode and operand presented
    input  wire logic        i_irq_pin,   // external interrupt pin level
    input  wire logic        i_irq_req,   // any interrupt request
    input  wire logic        i_ext_irq,   // external interrupt request
    input  wire logic        i_brk_req,   // break request level
    input  wire logic        i_brk_last,  // break match on last cycle
    input  wire logic        i_monitor,   // monitor mode
    input  wire logic [3:0]  i_addr,      // register address
    input  wire logic [7:0]  i_wdata,     // register write data
    input  wire logic        i_wr,        // write strobe
    input  wire logic        i_rd,        // read strobe
    output logic      [7:0]  o_rdata,     // read data, one cycle later
    output logic      [7:0]  o_ir,        // instruction register
    output logic      [15:0] o_pc,        // program counter
    output logic      [7:0]  o_cc,        // condition code register
    output logic             o_cpu_clk_en,// cpu clock gate
    output logic             o_in_break,  // break routine active
    output logic             o_ready      // core takes an instruction
);

    // ****************************************
    // state
    // ****************************************
    cfl_state_t  state;
    logic [7:0]  acc;
    logic [1:0]  cyc;
    logic [15:0] osc_cnt;
    logic        in_stop;
    logic        brk_pend;

    logic [7:0]  alu_res;
    logic        alu_c;
    logic        alu_upd_c;
    logic        br_is;
    logic        br_take;
    logic [15:0] br_target;
    logic        inst_end;
    logic        is_alu;

    // the settle counter is 16 bits wide
    if (OSC_CYCLES < 1 || OSC_CYCLES > 65535) begin : g_bad_osc
        $error("OSC_CYCLES out of range");
    end

    // ****************************************
    // datapath helpers
    // ****************************************
    cfl_alu u_alu (
        .i_op    (o_ir),
        .i_a     (acc),
        .i_m     (i_operand),
        .i_c     (o_cc[CFL_CC_C_BIT]),
        .o_res   (alu_res),
        .o_c     (alu_c),
        .o_upd_c (alu_upd_c)
    );

    cfl_branch u_br (
        .i_op      (o_ir),
        .i_pc      (o_pc),
        .i_rel     (i_operand),
        .i_c       (o_cc[CFL_CC_C_BIT]),
        .i_irq_pin (i_irq_pin),
        .o_is_br   (br_is),
        .o_take    (br_take),
        .o_target  (br_target)
    );

    function automatic logic alu_class(input logic [7:0] op);
        alu_class = (op == CFL_OP_ADD) || (op == CFL_OP_SUB) || (op == CFL_OP_AND) ||
                    (op == CFL_OP_LSL) || (op == CFL_OP_LSR) || (op == CFL_OP_ROL);
    endfunction

    // last execution cycle: branches need 3 cycles, others 1
    assign is_alu   = alu_class(o_ir);
    assign inst_end = (state == CFL_EXEC) &&
                      (br_is ? (cyc == 2'(CFL_BRANCH_CYCLES - 1)) : 1'b1);
    assign o_ready  = (state == CFL_FETCH) && ~brk_pend && ~i_brk_req;
    assign o_cpu_clk_en = (state != CFL_LOWPWR) && (state != CFL_OSCWAIT);

    // ****************************************
    // break request latch
    // ****************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            brk_pend <= 1'b0;
        end else if (i_ce) begin
            if (state == CFL_BREAK) begin
                brk_pend <= 1'b0;
            end else if (i_brk_req && state != CFL_FETCH) begin
                brk_pend <= 1'b1;
            end
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state    <= CFL_FETCH;
            o_ir     <= 8'h00;
            o_pc     <= 16'h0000;
            cyc      <= 2'h0;
            osc_cnt  <= 16'h0000;
            in_stop  <= 1'b0;
            o_in_break <= 1'b0;
        end else if (i_ce) begin
            case (state)
                CFL_FETCH: begin
                    cyc <= 2'h0;
                    if (brk_pend || i_brk_req) begin
                        state <= CFL_BREAK;
                    end else if (i_op_valid) begin
                        o_ir  <= i_opcode;
                        state <= CFL_EXEC;
                    end
                end
                CFL_EXEC: begin
                    cyc <= cyc + 2'h1;
                    if (inst_end) begin
                        if (br_is) begin
                            o_pc <= br_take ? br_target
                                            : o_pc + 16'(CFL_BRANCH_LEN);
                        end else begin
                            o_pc <= o_pc + 16'h0001;
                        end
                        if (o_ir == CFL_OP_WAIT) begin
                            state   <= CFL_LOWPWR;
                            in_stop <= 1'b0;
                        end else if (o_ir == CFL_OP_STOP) begin
                            state   <= CFL_LOWPWR;
                            in_stop <= 1'b1;
                        end else if (o_ir == CFL_OP_IRET && o_in_break) begin
                            if (!i_brk_req) begin
                                o_in_break <= 1'b0;
                            end
                            state <= (i_brk_req) ? CFL_BREAK : CFL_FETCH;
                        end else if (brk_pend || i_brk_last) begin
                            state <= CFL_BREAK;
                        end else begin
                            state <= CFL_FETCH;
                        end
                    end
                end
                CFL_LOWPWR: begin
                    // stop wakes only on external interrupts
                    if (in_stop ? i_ext_irq : i_irq_req) begin
                        if (in_stop) begin
                            osc_cnt <= 16'(OSC_CYCLES);
                            state   <= CFL_OSCWAIT;
                        end else begin
                            state <= CFL_FETCH;
                        end
                    end
                end
                CFL_OSCWAIT: begin
                    if (osc_cnt <= 16'h0001) begin
                        state <= CFL_FETCH;
                    end else begin
                        osc_cnt <= osc_cnt - 16'h0001;
                    end
                end
                CFL_BREAK: begin
                    o_ir       <= CFL_OP_TRAP;
                    o_pc       <= i_monitor ? CFL_VEC_MONITOR : CFL_VEC_BREAK;
                    o_in_break <= 1'b1;
                    state      <= CFL_FETCH;
                end
                default: state <= CFL_FETCH;
            endcase
        end
    end

    // ****************************************
    // accumulator and software writes
    // ****************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            acc <= 8'h00;
        end else if (i_ce) begin
            if (i_wr && i_addr == CFL_ADDR_ACC) begin
                acc <= i_wdata;
            end else if (inst_end && is_alu && o_ir != CFL_OP_AND) begin
                acc <= alu_res;
            end
        end
    end

    // ****************************************
    // condition codes
    // ****************************************
    // branches leave all flags untouched; reset and break entry set the mask, cc writes load it from the write data
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_cc <= CFL_CC_RESET;
        end else if (i_ce) begin
            if (i_wr && i_addr == CFL_ADDR_CC) begin
                o_cc <= i_wdata;
            end else if (inst_end) begin
                if (is_alu) begin
                    o_cc[CFL_CC_Z_BIT] <= (alu_res == 8'h00);
                    o_cc[CFL_CC_N_BIT] <= alu_res[7];
                    if (alu_upd_c) begin
                        o_cc[CFL_CC_C_BIT] <= alu_c;
                    end
                end else if (o_ir == CFL_OP_BRSET0) begin
                    o_cc[CFL_CC_C_BIT] <= acc[0];
                end else if (o_ir == CFL_OP_WAIT || o_ir == CFL_OP_STOP) begin
                    o_cc[CFL_CC_I_BIT] <= 1'b0;
                end
            end else if (state == CFL_BREAK) begin
                o_cc[CFL_CC_I_BIT] <= 1'b1;
            end
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            if (!i_rd) begin
                o_rdata <= 8'h00;
            end else if (i_addr == CFL_ADDR_CC) begin
                o_rdata <= o_cc;
            end else if (i_addr == CFL_ADDR_ACC) begin
                o_rdata <= acc;
            end else if (i_addr == CFL_ADDR_PCH) begin
                o_rdata <= o_pc[15:8];
            end else if (i_addr == CFL_ADDR_PCL) begin
                o_rdata <= o_pc[7:0];
            end else if (i_addr == CFL_ADDR_STAT) begin
                o_rdata <= {5'h00, o_in_break, in_stop, ~o_cpu_clk_en};
            end else begin
                o_rdata <= 8'h00;
            end
        end
    end

endmodule // cfl_core

// file: cfl_core_sva.sv
// assertion checker for the flag, low-power and break core
`timescale 1ns/1ps
module cfl_core_sva
    import cfl_pkg::*;
#(
    parameter int OSC_CYCLES = 8  // oscillator settling count
)(
    input  wire logic        i_clk,        // bus clock
    input  wire logic        i_sys_rst,    // async reset
    input  wire logic [7:0]  i_opcode,     // opcode
    input  wire logic        i_op_valid,   // opcode offered
    input  wire logic        i_ext_irq,    // stop wake request
    input  wire logic        i_brk_req,    // break request
    input  wire logic        i_monitor,    // monitor mode
    input  wire logic        i_rd,         // read strobe
    input  wire logic [7:0]  o_rdata,      // read data
    input  wire logic [7:0]  o_ir,         // instruction register
    input  wire logic [15:0] o_pc,         // program counter
    input  wire logic [7:0]  o_cc,         // flags
    input  wire logic        o_cpu_clk_en, // cpu clock gate
    input  wire logic        o_in_break,   // break active
    input  wire logic        o_ready       // fetch ready
);
    // ****************************************
    // helper logic
    // ****************************************
    localparam int OSC_HI = OSC_CYCLES + 4;
    logic        in_stop;
    logic [15:0] wake_cnt;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // remembers a stop, so the settle count is told apart from wait
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) in_stop <= 1'b0;
        else if (o_ready && i_op_valid && i_opcode == CFL_OP_STOP) in_stop <= 1'b1;
        else if (o_cpu_clk_en && wake_cnt != 16'h0000) in_stop <= 1'b0;
    end
    // counts gated cycles from the wake edge on
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) wake_cnt <= 16'h0000;
        else if (o_cpu_clk_en) wake_cnt <= 16'h0000;
        else if (in_stop && (i_ext_irq || wake_cnt != 16'h0000)) wake_cnt <= wake_cnt + 16'h0001;
    end

    // ****************************************
    // properties
    // ****************************************
    sequence s_take(logic [7:0] op);
        o_ready && i_op_valid && i_opcode == op;
    endsequence
    sequence s_asleep;
        !o_cpu_clk_en && !o_cc[CFL_CC_I_BIT];
    endsequence
    sequence s_wake;
        in_stop && !o_cpu_clk_en && i_ext_irq && wake_cnt == 16'h0000;
    endsequence
    sequence s_branch;
        o_ready && i_op_valid && !i_brk_req &&
        (i_opcode == CFL_OP_BGEU || i_opcode == CFL_OP_BPHI || i_opcode == CFL_OP_BPLO);
    endsequence

    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside its answer cycle");
    a_wait_mask: assert property (s_take(CFL_OP_WAIT) |-> ##[1:3] s_asleep)
        else $error("wait left the clock or the mask on");
    a_stop_mask: assert property (s_take(CFL_OP_STOP) |-> ##[1:3] s_asleep)
        else $error("stop left the clock or the mask on");
    a_osc_hold: assert property ($rose(o_cpu_clk_en) && in_stop |-> wake_cnt >= OSC_CYCLES)
        else $error("clock restarted before the settle delay");
    a_osc_bound: assert property (s_wake |-> ##[1:OSC_HI] o_cpu_clk_en)
        else $error("clock did not restart after the settle delay");
    a_break_load: assert property ($rose(o_in_break) |-> o_ir == CFL_OP_TRAP && o_cc[CFL_CC_I_BIT]
        && o_pc == ($past(i_monitor) ? CFL_VEC_MONITOR : CFL_VEC_BREAK))
        else $error("break entry loaded wrong opcode, vector or mask");
    a_return_exit: assert property ((o_in_break && !i_brk_req) ##0 s_take(CFL_OP_IRET) |-> ##[1:3] !o_in_break)
        else $error("return did not end the break");
    a_branch_cycles: assert property (s_branch |=> (!o_ready && $stable(o_cc))[*3])
        else $error("branch length or flags wrong");
endmodule // cfl_core_sva

// file: cfl_core_tb.sv
// self-checking bench for the flag, low-power and break core
`timescale 1ns/1ps
module cfl_core_tb;
    import cfl_pkg::*;
    // ****************************************
    // signals and helpers
    // ****************************************
    localparam int OSC_SIM = 8;  // short settle count keeps the run brief
    localparam logic [7:0] OPS [6] = '{CFL_OP_ADD, CFL_OP_SUB, CFL_OP_AND,
                                       CFL_OP_LSL, CFL_OP_LSR, CFL_OP_ROL};
    logic        i_clk, i_sys_rst, i_ce, i_op_valid, i_irq_pin, i_irq_req;
    logic        i_ext_irq, i_brk_req, i_brk_last, i_monitor, i_wr, i_rd;
    logic [7:0]  i_opcode, i_operand, i_wdata, o_rdata, o_ir, o_cc, a, m, d, op;
    logic [3:0]  i_addr;
    logic [15:0] o_pc, pcm;
    logic        o_cpu_clk_en, o_in_break, o_ready;
    logic [31:0] seed;
    logic [8:0]  r;
    int          errors, cmp_count, cyc, n;

    cfl_core #(.OSC_CYCLES(OSC_SIM)) i_cfl_core (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_opcode(i_opcode),
        .i_operand(i_operand), .i_op_valid(i_op_valid), .i_irq_pin(i_irq_pin),
        .i_irq_req(i_irq_req), .i_ext_irq(i_ext_irq), .i_brk_req(i_brk_req),
        .i_brk_last(i_brk_last), .i_monitor(i_monitor), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ir(o_ir), .o_pc(o_pc), .o_cc(o_cc),
        .o_cpu_clk_en(o_cpu_clk_en), .o_in_break(o_in_break), .o_ready(o_ready)
    );

    // clock and a cycle ceiling so a hang still ends in a verdict
    initial i_clk = 1'b0;
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            $display("BAD %0t timeout", $time);
            tally_and_finish();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // carry in bit 8, byte result below; and keeps carry
    function automatic logic [8:0] alu_exp(input logic [7:0] o, x, y, input logic c);
        case (o)
            CFL_OP_ADD: return {1'b0, x} + {1'b0, y};
            CFL_OP_SUB: return {1'b0, x} - {1'b0, y};
            CFL_OP_LSL: return {x, 1'b0};
            CFL_OP_LSR: return {x[0], 1'b0, x[7:1]};
            CFL_OP_ROL: return {x, c};
            default:    return {c, x & y};
        endcase
    endfunction
    function automatic logic [15:0] br_exp(input logic [15:0] pc, input logic [7:0] off,
                                           input logic take);
        return pc + 16'h0002 + (take ? {{8{off[7]}}, off} : 16'h0000);
    endfunction

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t byte %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t word %h want %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] adr, input logic [7:0] dat);
        @(posedge i_clk);
        i_addr <= adr;
        i_wdata <= dat;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] adr, output logic [7:0] dat);
        @(posedge i_clk);
        i_addr <= adr;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        dat = o_rdata;
    endtask
    // offer one instruction; returns on its take edge, operand held
    task automatic run(input logic [7:0] opc, input logic [7:0] opr);
        int t;
        @(posedge i_clk);
        i_opcode <= opc;
        i_operand <= opr;
        i_op_valid <= 1'b1;
        t = 0;
        do begin
            @(negedge i_clk);
            t++;
        end while (o_ready !== 1'b1 && t < 40);
        @(posedge i_clk);
        i_op_valid <= 1'b0;
    endtask
    task automatic wait_ready(output int cnt);
        cnt = 0;
        do begin
            @(negedge i_clk);
            cnt++;
        end while (o_ready !== 1'b1 && cnt < 100);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        i_sys_rst = 1'b1;
        i_ce = 1'b1;
        {i_op_valid, i_irq_pin, i_irq_req, i_ext_irq, i_brk_req, i_brk_last} = '0;
        {i_monitor, i_wr, i_rd, i_opcode, i_operand, i_wdata, i_addr} = '0;
        seed = 32'd19;
        pcm = 16'h0000;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        reg_rd(CFL_ADDR_CC, d);
        cmp8(d, CFL_CC_RESET);
        reg_wr(CFL_ADDR_CTRL, 8'h5a);
        reg_rd(CFL_ADDR_CTRL, d);
        cmp8(d, 8'h00);
        // branches: each condition taken then not, extreme offsets first
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            d = (k == 0) ? 8'h80 : (k == 1) ? 8'h7f : seed[7:0];
            op = (k % 3 == 0) ? CFL_OP_BGEU : (k % 3 == 1) ? CFL_OP_BPHI : CFL_OP_BPLO;
            i_irq_pin <= (k < 3) ^ (op == CFL_OP_BPLO);
            reg_wr(CFL_ADDR_CC, {7'h30, k >= 3});
            run(op, d);
            wait_ready(n);
            cmp8(n[7:0], 8'(CFL_BRANCH_CYCLES + 1));
            pcm = br_exp(pcm, d, k < 3);
            cmp16(o_pc, pcm);
            cmp8(o_cc, {7'h30, k >= 3});
        end
        // alu: carry out and zero result corners, then random operations
        for (int k = 0; k < 24; k++) begin
            seed = xs(seed);
            a = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : seed[7:0];
            m = (k < 2) ? 8'h01 : seed[15:8];
            op = OPS[(k < 2) ? k : seed[31:16] % 6];
            reg_wr(CFL_ADDR_ACC, a);
            reg_wr(CFL_ADDR_CC, {7'h30, seed[24]});
            run(op, m);
            wait_ready(n);
            r = alu_exp(op, a, m, seed[24]);
            pcm = pcm + 16'h0001;
            cmp8({7'h00, o_cc[CFL_CC_C_BIT]}, {7'h00, r[8]});
            cmp8({7'h00, o_cc[CFL_CC_Z_BIT]}, {7'h00, r[7:0] == 8'h00});
            cmp16(o_pc, pcm);
            reg_rd(CFL_ADDR_ACC, d);
            cmp8(d, (op == CFL_OP_AND) ? a : r[7:0]);
        end
        // bit test: carry follows accumulator bit 0; pc no longer tracked
        reg_wr(CFL_ADDR_ACC, 8'h01);
        reg_wr(CFL_ADDR_CC, 8'h60);
        run(CFL_OP_BRSET0, 8'h00);
        wait_ready(n);
        cmp8({7'h00, o_cc[CFL_CC_C_BIT]}, 8'h01);
        // break from fetch, during a branch (monitor), and on a last-cycle match
        for (int k = 0; k < 3; k++) begin
            i_monitor <= (k == 1);
            if (k == 0) begin
                @(posedge i_clk);
                i_brk_req <= 1'b1;
            end else begin
                run((k == 1) ? CFL_OP_BGEU : CFL_OP_ADD, 8'h10);
                if (k == 1) i_brk_req <= 1'b1;
                else i_brk_last <= 1'b1;
            end
            @(posedge i_clk);
            i_brk_last <= 1'b0;
            n = 0;
            do begin
                @(negedge i_clk);
                n++;
            end while (o_in_break !== 1'b1 && n < 20);
            @(posedge i_clk);
            i_brk_req <= 1'b0;
            cmp8({7'h00, (k == 1) ? n >= 3 : n <= 2}, 8'h01);
            cmp8(o_ir, CFL_OP_TRAP);
            cmp16(o_pc, (k == 1) ? CFL_VEC_MONITOR : CFL_VEC_BREAK);
            run(CFL_OP_IRET, 8'h00);
            wait_ready(n);
            cmp8({7'h00, o_in_break}, 8'h00);
        end
        // wait then stop, each entered with the mask set, left by interrupt
        for (int k = 0; k < 2; k++) begin
            reg_wr(CFL_ADDR_CC, CFL_CC_RESET);
            run((k == 0) ? CFL_OP_WAIT : CFL_OP_STOP, 8'h00);
            repeat (4) @(negedge i_clk);
            cmp8({6'h00, o_cpu_clk_en, o_cc[CFL_CC_I_BIT]}, 8'h00);
            @(posedge i_clk);
            if (k == 0) i_irq_req <= 1'b1;
            else i_ext_irq <= 1'b1;
            @(posedge i_clk);
            {i_irq_req, i_ext_irq} <= 2'b00;
            wait_ready(n);
            cmp8({7'h00, k == 0 || n >= OSC_SIM}, 8'h01);
            cmp8({6'h00, o_cpu_clk_en, o_cc[CFL_CC_I_BIT]}, 8'h02);
        end
        // reset out of wait sets the mask again
        run(CFL_OP_WAIT, 8'h00);
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(negedge i_clk);
        cmp8(o_cc, CFL_CC_RESET);
        cmp8({7'h00, o_cpu_clk_en}, 8'h01);
        cmp16(o_pc, 16'h0000);
        tally_and_finish();
    end
endmodule // cfl_core_tb

bind cfl_core cfl_core_sva #(.OSC_CYCLES(OSC_CYCLES)) i_cfl_core_sva (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_opcode(i_opcode), .i_op_valid(i_op_valid),
    .i_ext_irq(i_ext_irq), .i_brk_req(i_brk_req), .i_monitor(i_monitor), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_ir(o_ir), .o_pc(o_pc), .o_cc(o_cc),
    .o_cpu_clk_en(o_cpu_clk_en), .o_in_break(o_in_break), .o_ready(o_ready)
);
